// file: core/flf_top.sv
// fault latch with flash code lamps, relays and ahb-lite registers
// Functional notes
// - sixteen error groups, four-bit group index
// - sixteen details per group, group plus detail
// - error state held until acknowledged
// - error state drives the ok relay and the error lamp
// - acknowledge only on rising acknowledge edge
// - acknowledge from pin or software bit
// - warnings latched, cleared by same edge
// - error lamp flashes group then detail
// - warnings flash on the status lamp
// - flash counts encode group and detail
// - warnings use identical code encoding
// - pending codes shown in turn, wrapping
// - latched codes readable over the bus
// - index n gives n plus one flashes
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
module flf_top
#(
    parameter int unsigned FLASH_ON_CYC  = 32'(flf_pkg::FLASH_ON_CYC),
    parameter int unsigned FLASH_OFF_CYC = 32'(flf_pkg::FLASH_OFF_CYC),
    parameter int unsigned PHASE_GAP_CYC = 32'(flf_pkg::PHASE_GAP_CYC),
    parameter int unsigned CODE_GAP_CYC  = 32'(flf_pkg::CODE_GAP_CYC)
)
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst_b,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic [1:0]                  hresp,
    output logic [31:0]                 hrdata,
    input  wire flf_pkg::flf_event_type err_event,
    input  wire flf_pkg::flf_event_type warn_event,
    input  wire logic                   ack_pin,
    output logic                        relay_ok,
    output logic                        relay_warn,
    output logic                        led_error,
    output logic                        led_status
);

    logic                  rst_meta;
    logic                  rst_sync_b;
    logic                  ack_meta;
    logic                  ack_sync;
    logic                  ack_prev;
    logic                  ctrl_ack;
    logic                  ctrl_prev;
    logic [2:0]            pend_sel;
    logic                  wr_pend;
    logic [7:0]            wr_addr;
    logic [255:0]          pend [2];
    logic [1:0]            flag;
    logic [7:0]            ptr [2];
    logic [1:0]            lamp;
    logic [1:0]            fl_led;
    logic [1:0]            fl_busy;
    logic [1:0]            fl_done;
    logic [1:0]            fl_start;
    flf_pkg::flf_code_type last [2];
    flf_pkg::flf_event_type evt [2];
    wire                   pin_rise;
    wire                   sw_rise;
    wire                   ack_rise;
    wire                   addr_ok;
    wire                   rd_take;
    wire  [7:0]            rd_addr;
    wire  [7:0]            pend_base;
    wire  [31:0]           status_word;
    wire  [31:0]           show_word;
    wire  [31:0]           rd_value;
    wire                   wr_ctrl;
    wire                   wr_sel;

    // reset release
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta   <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta   <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    // acknowledge pin synchroniser and edge history
    always_ff @(posedge sys_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            ack_meta  <= 1'b0;
            ack_sync  <= 1'b0;
            ack_prev  <= 1'b0;
            ctrl_prev <= flf_pkg::CTRL_ACK_RESET;
        end
        else
        begin
            ack_meta  <= ack_pin;
            ack_sync  <= ack_meta;
            ack_prev  <= ack_sync;
            ctrl_prev <= ctrl_ack;
        end
    end

    assign pin_rise = ack_sync & ~ack_prev;
    assign sw_rise  = ctrl_ack & ~ctrl_prev;
    assign ack_rise = pin_rise | sw_rise;

    // ahb-lite slave, zero wait states
    assign addr_ok     = hsel & htrans[1] & hready;
    assign rd_take     = addr_ok & ~hwrite;
    assign rd_addr     = haddr[7:0];
    assign pend_base   = {pend_sel, 5'h00};
    assign wr_ctrl     = wr_pend && (wr_addr == flf_pkg::ADDR_CTRL);
    assign wr_sel      = wr_pend && (wr_addr == flf_pkg::ADDR_PEND_SEL);
    assign status_word = {8'h00, last[flf_pkg::KIND_WARN],
                          last[flf_pkg::KIND_ERR], 6'h00, flag};
    assign show_word   = {fl_busy[flf_pkg::KIND_WARN], 7'h00,
                          ptr[flf_pkg::KIND_WARN],
                          fl_busy[flf_pkg::KIND_ERR], 7'h00,
                          ptr[flf_pkg::KIND_ERR]};
    assign rd_value =
        (rd_addr == flf_pkg::ADDR_CTRL)      ? {31'h0, ctrl_ack} :
        (rd_addr == flf_pkg::ADDR_STATUS)    ? status_word :
        (rd_addr == flf_pkg::ADDR_PEND_SEL)  ? {29'h0, pend_sel} :
        (rd_addr == flf_pkg::ADDR_ERR_PEND)  ?
            pend[flf_pkg::KIND_ERR][pend_base +: 32] :
        (rd_addr == flf_pkg::ADDR_WARN_PEND) ?
            pend[flf_pkg::KIND_WARN][pend_base +: 32] :
        (rd_addr == flf_pkg::ADDR_SHOW)      ? show_word :
        32'h0000_0000;
    assign hreadyout = 1'b1;
    assign hresp     = flf_pkg::HRESP_OKAY;

    always_ff @(posedge sys_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata  <= flf_pkg::RDATA_RESET;
        end
        else
        begin
            wr_pend <= addr_ok & hwrite;
            wr_addr <= rd_addr;
            hrdata  <= rd_take ? rd_value : flf_pkg::RDATA_RESET;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            ctrl_ack <= flf_pkg::CTRL_ACK_RESET;
            pend_sel <= flf_pkg::PEND_SEL_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_ack <= hwdata[flf_pkg::CTRL_ACK_BIT];
            if (wr_sel)
                pend_sel <= hwdata[flf_pkg::SEL_MSB:0];
        end
    end

    assign evt[flf_pkg::KIND_ERR]  = err_event;
    assign evt[flf_pkg::KIND_WARN] = warn_event;

    // one latch, scanner and flasher per kind: errors, warnings
    genvar k;
    generate
        for (k = 0; k < 2; k++)
        begin : g_kind
            wire hit;
            assign hit = pend[k][ptr[k]];
            assign fl_start[k] = hit & ~fl_busy[k] & ~fl_done[k];

            always_ff @(posedge sys_clk or negedge rst_sync_b)
            begin
                if (!rst_sync_b)
                begin
                    pend[k] <= '0;
                    flag[k] <= 1'b0;
                    last[k] <= '0;
                end
                else
                begin
                    if (ack_rise)
                    begin
                        pend[k] <= '0;
                        flag[k] <= 1'b0;
                    end
                    if (evt[k].valid)
                    begin
                        pend[k][evt[k].code] <= 1'b1;
                        flag[k] <= 1'b1;
                        last[k] <= evt[k].code;
                    end
                end
            end

            always_ff @(posedge sys_clk or negedge rst_sync_b)
            begin
                if (!rst_sync_b)
                begin
                    ptr[k]  <= 8'h00;
                    lamp[k] <= 1'b0;
                end
                else
                begin
                    if (fl_done[k] || (!fl_busy[k] && !hit))
                        ptr[k] <= ptr[k] + 8'h01;
                    lamp[k] <= flag[k] & fl_led[k];
                end
            end

            flf_flash
            #(
                .ON_CYC    (FLASH_ON_CYC),
                .OFF_CYC   (FLASH_OFF_CYC),
                .PHASE_CYC (PHASE_GAP_CYC),
                .CODE_CYC  (CODE_GAP_CYC)
            )
            u_flash
            (
                .sys_clk    (sys_clk),
                .rst_sync_b (rst_sync_b),
                .start      (fl_start[k]),
                .code       (flf_pkg::flf_code_type'(ptr[k])),
                .led        (fl_led[k]),
                .busy       (fl_busy[k]),
                .done       (fl_done[k])
            );
        end
    endgenerate

    // relays and lamps
    always_ff @(posedge sys_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            relay_ok   <= 1'b0;
            relay_warn <= 1'b0;
        end
        else
        begin
            relay_ok   <= ~flag[flf_pkg::KIND_ERR];
            relay_warn <= flag[flf_pkg::KIND_WARN];
        end
    end

    assign led_error  = lamp[flf_pkg::KIND_ERR];
    assign led_status = lamp[flf_pkg::KIND_WARN];

    default clocking top_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_sync_b);

    a_error_hold: assert property (
        flag[0] && !ack_rise |=> flag[0]
    ) else $error("error state dropped without acknowledge");

    a_ack_clears: assert property (
        ack_rise && !err_event.valid |=> !flag[0] && pend[0] == '0
    ) else $error("acknowledge did not clear errors");

    a_warn_clears: assert property (
        ack_rise && !warn_event.valid |=> !flag[1] && pend[1] == '0
    ) else $error("acknowledge did not clear warnings");

    a_pin_edge: assert property (
        $rose(ack_sync) |-> ack_rise ##1 !pin_rise
    ) else $error("pin edge not taken once");

    a_sw_ack: assert property (
        wr_ctrl && hwdata[0] && !ctrl_ack |=> ack_rise
    ) else $error("software acknowledge ignored");

    a_err_index: assert property (
        err_event.valid |=> pend[0][$past(err_event.code)] && flag[0]
    ) else $error("error not latched at its index");

    a_warn_index: assert property (
        warn_event.valid |=> pend[1][$past(warn_event.code)]
    ) else $error("warning not latched at its index");

    a_relay_alarm: assert property (
        flag[0] ##1 flag[0] |-> !relay_ok
    ) else $error("ok relay closed in error state");

    a_err_lamp_dark: assert property (
        !flag[0] |=> !led_error
    ) else $error("error lamp lit without error");

    a_warn_lamp_dark: assert property (
        !flag[1] |=> !led_status
    ) else $error("status lamp lit without warning");

    a_ptr_wrap: assert property (
        ptr[0] == 8'hff && !fl_busy[0] && !fl_start[0] |=> ptr[0] == 8'h00
    ) else $error("scan did not wrap to first code");

    a_status_read: assert property (
        rd_take && rd_addr == flf_pkg::ADDR_STATUS
        |=> hrdata[1:0] == $past(flag) && hreadyout
    ) else $error("status read wrong");

    c_err_flash: cover property (fl_start[0] ##2 led_error);
    c_warn_flash: cover property (fl_start[1]);
    c_pin_ack: cover property (flag[0] && pin_rise);
    c_two_codes: cover property (fl_done[0] ##[1:300] fl_start[0]);

endmodule // flf_top

// file: core/flf_pkg.sv
// shared constants and types for the fault latch and flash indicator
package flf_pkg;

    // clock and flash timing
    localparam longint unsigned CLK_HZ        = 64'd25_000_000;
    localparam longint unsigned MS_PER_S      = 64'd1000;
    localparam longint unsigned FLASH_ON_MS   = 64'd300;
    localparam longint unsigned FLASH_OFF_MS  = 64'd300;
    localparam longint unsigned PHASE_GAP_MS  = 64'd1000;
    localparam longint unsigned CODE_GAP_MS   = 64'd2000;
    localparam longint unsigned FLASH_ON_CYC  = FLASH_ON_MS * CLK_HZ / MS_PER_S;
    localparam longint unsigned FLASH_OFF_CYC = FLASH_OFF_MS * CLK_HZ / MS_PER_S;
    localparam longint unsigned PHASE_GAP_CYC = PHASE_GAP_MS * CLK_HZ / MS_PER_S;
    localparam longint unsigned CODE_GAP_CYC  = CODE_GAP_MS * CLK_HZ / MS_PER_S;

    // code space
    localparam int unsigned     CODE_COUNT    = 256;
    localparam int unsigned     KIND_ERR      = 0;
    localparam int unsigned     KIND_WARN     = 1;

    // register byte offsets
    localparam logic [7:0]      ADDR_CTRL      = 8'h00;
    localparam logic [7:0]      ADDR_STATUS    = 8'h04;
    localparam logic [7:0]      ADDR_PEND_SEL  = 8'h08;
    localparam logic [7:0]      ADDR_ERR_PEND  = 8'h0c;
    localparam logic [7:0]      ADDR_WARN_PEND = 8'h10;
    localparam logic [7:0]      ADDR_SHOW      = 8'h14;

    // field positions
    localparam int unsigned     CTRL_ACK_BIT   = 0;
    localparam int unsigned     SEL_MSB        = 2;

    // reset values
    localparam logic            CTRL_ACK_RESET = 1'b0;
    localparam logic [2:0]      PEND_SEL_RESET = 3'h0;
    localparam logic [31:0]     RDATA_RESET    = 32'h0000_0000;

    // bus encodings
    localparam logic [1:0]      HRESP_OKAY     = 2'b00;

    typedef struct packed {
        logic [3:0] group;
        logic [3:0] detail;
    } flf_code_type;

    typedef struct packed {
        logic         valid;
        flf_code_type code;
    } flf_event_type;

    typedef enum logic [2:0] {
        FL_IDLE      = 3'b000,
        FL_ON        = 3'b001,
        FL_OFF       = 3'b010,
        FL_PHASE_GAP = 3'b011,
        FL_CODE_GAP  = 3'b100
    } flf_flash_state_type;

endpackage

// file: core/flf_flash.sv
// flash code sequencer for one lamp: group flashes, gap, detail flashes
`timescale 1ns/10ps
module flf_flash
#(
    parameter int unsigned ON_CYC    = 32'd10,
    parameter int unsigned OFF_CYC   = 32'd10,
    parameter int unsigned PHASE_CYC = 32'd20,
    parameter int unsigned CODE_CYC  = 32'd40
)
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_sync_b,
    input  wire logic                  start,
    input  wire flf_pkg::flf_code_type code,
    output logic                       led,
    output logic                       busy,
    output logic                       done
);

    localparam logic [31:0] ON_LOAD    = 32'(ON_CYC - 1);
    localparam logic [31:0] OFF_LOAD   = 32'(OFF_CYC - 1);
    localparam logic [31:0] PHASE_LOAD = 32'(PHASE_CYC - 1);
    localparam logic [31:0] CODE_LOAD  = 32'(CODE_CYC - 1);

    flf_pkg::flf_flash_state_type state;
    flf_pkg::flf_flash_state_type next_state;
    flf_pkg::flf_code_type        code_q;
    flf_pkg::flf_code_type        next_code;
    logic [31:0]                  timer;
    logic [31:0]                  next_timer;
    logic [4:0]                   flashes;
    logic [4:0]                   next_flashes;
    logic                         phase;
    logic                         next_phase;
    wire                          timer_zero;
    wire  [4:0]                   target;

    assign timer_zero = (timer == 32'h0000_0000);
    assign target     = phase ? ({1'b0, code_q.detail} + 5'h01)
                              : ({1'b0, code_q.group} + 5'h01);
    assign busy       = (state != flf_pkg::FL_IDLE);

    always_comb
    begin
        next_state   = state;
        next_code    = code_q;
        next_flashes = flashes;
        next_phase   = phase;
        next_timer   = timer_zero ? timer : timer - 32'h0000_0001;
        unique case (state)
            flf_pkg::FL_IDLE:
            begin
                if (start)
                begin
                    next_code    = code;
                    next_phase   = 1'b0;
                    next_flashes = 5'h00;
                    next_timer   = ON_LOAD;
                    next_state   = flf_pkg::FL_ON;
                end
            end
            flf_pkg::FL_ON:
            begin
                if (timer_zero)
                begin
                    next_flashes = flashes + 5'h01;
                    next_timer   = OFF_LOAD;
                    next_state   = flf_pkg::FL_OFF;
                end
            end
            flf_pkg::FL_OFF:
            begin
                if (timer_zero && flashes == target && !phase)
                begin
                    next_phase = 1'b1;
                    next_timer = PHASE_LOAD;
                    next_state = flf_pkg::FL_PHASE_GAP;
                end
                else if (timer_zero && flashes == target)
                begin
                    next_timer = CODE_LOAD;
                    next_state = flf_pkg::FL_CODE_GAP;
                end
                else if (timer_zero)
                begin
                    next_timer = ON_LOAD;
                    next_state = flf_pkg::FL_ON;
                end
            end
            flf_pkg::FL_PHASE_GAP:
            begin
                if (timer_zero)
                begin
                    next_flashes = 5'h00;
                    next_timer   = ON_LOAD;
                    next_state   = flf_pkg::FL_ON;
                end
            end
            flf_pkg::FL_CODE_GAP:
            begin
                if (timer_zero)
                begin
                    next_state = flf_pkg::FL_IDLE;
                end
            end
            default:
            begin
                next_state = flf_pkg::FL_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            state   <= flf_pkg::FL_IDLE;
            code_q  <= '0;
            timer   <= 32'h0000_0000;
            flashes <= 5'h00;
            phase   <= 1'b0;
            led     <= 1'b0;
            done    <= 1'b0;
        end
        else
        begin
            state   <= next_state;
            code_q  <= next_code;
            timer   <= next_timer;
            flashes <= next_flashes;
            phase   <= next_phase;
            led     <= (next_state == flf_pkg::FL_ON);
            done    <= (state == flf_pkg::FL_CODE_GAP) && timer_zero;
        end
    end

    default clocking fl_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_sync_b);

    a_start_lights: assert property (
        start && state == flf_pkg::FL_IDLE |=> led && state == flf_pkg::FL_ON
    ) else $error("flash start did not light lamp");

    a_group_count: assert property (
        $rose(phase) |-> $past(flashes) == ({1'b0, code_q.group} + 5'h01)
    ) else $error("group flash count wrong");

    a_detail_count: assert property (
        $rose(state == flf_pkg::FL_CODE_GAP)
        |-> flashes == ({1'b0, code_q.detail} + 5'h01)
    ) else $error("detail flash count wrong");

    a_done_dark: assert property (
        done |-> state == flf_pkg::FL_IDLE && !led && !busy
    ) else $error("done while still flashing");

endmodule // flf_flash

// file: verif/flf_panel.sv
// panel model: lamp flash decoder and acknowledge switch
`timescale 1ns/10ps
module flf_panel
#(
    parameter int OFF_CYC  = 4,
    parameter int CODE_CYC = 12
)
(
    input  wire logic sys_clk,
    input  wire logic led,
    output logic      ack_pin,
    output logic [7:0] code,
    output logic [7:0] code_seen
);
    int   run = 0;
    int   flashes = 0;
    int   grp = 0;
    logic led_q = 1'b0;

    initial
    begin
        ack_pin = 1'b0;
        code = 8'h00;
        code_seen = 8'h00;
    end

    // switch held several cycles at each level
    task automatic set_ack(input logic v);
    begin
        @(posedge sys_clk);
        ack_pin <= v;
        repeat (3) @(posedge sys_clk);
    end
    endtask

    // long low run after a burst ends a phase
    always @(posedge sys_clk)
    begin
        led_q <= led;
        if (led && !led_q)
        begin
            if (run > OFF_CYC && flashes > 0)
            begin
                grp = flashes;
                flashes = 0;
            end
            flashes = flashes + 1;
            run = 0;
        end
        else if (!led)
        begin
            run = run + 1;
            if (run == OFF_CYC + CODE_CYC)
            begin
                if (grp > 0)
                begin
                    code <= 8'((grp - 1) * 16 + flashes - 1);
                    code_seen <= code_seen + 8'h01;
                end
                grp = 0;
                flashes = 0;
            end
        end
    end
endmodule // flf_panel

// file: verif/fault_latch_flash_indicator_tb.sv
// testbench for the fault latch and flash indicator
`timescale 1ns/10ps
module fault_latch_flash_indicator_tb;
    logic                   sys_clk = 1'b0;
    logic                   rst_b = 1'b0;
    logic                   hsel = 1'b0;
    logic [31:0]            haddr = 32'h0;
    logic [1:0]             htrans = 2'h0;
    logic                   hwrite = 1'b0;
    logic [2:0]             hsize = 3'h0;
    logic [31:0]            hwdata = 32'h0;
    logic                   hreadyout;
    logic [1:0]             hresp;
    logic [31:0]            hrdata;
    flf_pkg::flf_event_type err_event = '0;
    flf_pkg::flf_event_type warn_event = '0;
    logic                   ack_pin;
    logic                   relay_ok;
    logic                   relay_warn;
    logic                   led_error;
    logic                   led_status;
    logic [7:0]             err_code;
    logic [7:0]             warn_code;
    logic [7:0]             err_seen;
    logic [7:0]             warn_seen;
    logic [31:0]            rd;
    logic [7:0]             c;
    int                     failures = 0;
    int                     tests_run = 0;

    always #20 sys_clk = ~sys_clk;

    flf_top #(
        .FLASH_ON_CYC (4),
        .FLASH_OFF_CYC(4),
        .PHASE_GAP_CYC(8),
        .CODE_GAP_CYC (12)
    ) dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .err_event(err_event), .warn_event(warn_event),
        .ack_pin(ack_pin), .relay_ok(relay_ok), .relay_warn(relay_warn),
        .led_error(led_error), .led_status(led_status)
    );

    flf_panel red (
        .sys_clk(sys_clk), .led(led_error), .ack_pin(ack_pin),
        .code(err_code), .code_seen(err_seen)
    );

    flf_panel yellow (
        .sys_clk(sys_clk), .led(led_status), .ack_pin(),
        .code(warn_code), .code_seen(warn_seen)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
    begin
        @(posedge sys_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        haddr  <= {24'h0, a};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    end
    endtask

    task automatic fire(input logic warn, input logic [7:0] code);
    begin
        @(posedge sys_clk);
        if (warn)
            warn_event <= {1'b1, code};
        else
            err_event <= {1'b1, code};
        @(posedge sys_clk);
        err_event  <= '0;
        warn_event <= '0;
        repeat (3) @(posedge sys_clk);
    end
    endtask

    task automatic get_code(input logic warn, output logic [7:0] got);
        logic [7:0] s;
        int         n;
    begin
        s = warn ? warn_seen : err_seen;
        n = 0;
        while ((warn ? warn_seen : err_seen) === s && n < 3000)
        begin
            @(posedge sys_clk);
            n = n + 1;
        end
        if (n >= 3000)
            check(32'h1, 32'h0);
        got = warn ? warn_code : err_code;
    end
    endtask

    task automatic end_of_test();
    begin
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask

    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check({relay_ok, relay_warn, led_error, led_status}, 4'h8);
        check({hresp, hreadyout}, 32'h1);
        bus(1'b0, 8'h04, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 8'h18, 32'h0);
        check(rd, 32'h0);
        red.set_ack(1'b1);
        fire(1'b0, 8'h21);
        check(relay_ok, 32'h0);
        bus(1'b1, 8'h08, 32'h1);
        bus(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h2);
        get_code(1'b0, c);
        check(c, 8'h21);
        red.set_ack(1'b0);
        check(relay_ok, 32'h0);
        fire(1'b0, 8'h03);
        fire(1'b1, 8'h21);
        bus(1'b0, 8'h04, 32'h0);
        check(rd, 32'h0021_0303);
        bus(1'b0, 8'h10, 32'h0);
        check(rd, 32'h2);
        check(relay_warn, 32'h1);
        get_code(1'b1, c);
        check(c, 8'h21);
        for (int i = 0; i < 3 && c !== 8'h03; i++)
            get_code(1'b0, c);
        get_code(1'b0, c);
        check(c, 8'h21);
        get_code(1'b0, c);
        check(c, 8'h03);
        red.set_ack(1'b1);
        repeat (4) @(posedge sys_clk);
        check({relay_ok, relay_warn, led_error, led_status}, 4'h8);
        bus(1'b0, 8'h04, 32'h0);
        check(rd & 32'h3, 32'h0);
        bus(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0);
        fire(1'b0, 8'hf0);
        bus(1'b0, 8'h04, 32'h0);
        check(rd & 32'hff03, 32'hf001);
        get_code(1'b0, c);
        check(c, 8'hf0);
        bus(1'b1, 8'h00, 32'h1);
        bus(1'b0, 8'h00, 32'h0);
        check(rd, 32'h1);
        check(relay_ok, 32'h1);
        bus(1'b1, 8'h00, 32'h0);
        end_of_test();
    end

    initial
    begin
        repeat (40000) @(posedge sys_clk);
        failures = failures + 1;
        end_of_test();
    end
endmodule // fault_latch_flash_indicator_tb
